// ===== design/sat_defines.svh
`ifndef SAT_DEFINES_SVH
`define SAT_DEFINES_SVH

// Register addresses on the special function register port
`define SAT_ADDR_CTRL      8'h91
`define SAT_ADDR_RLD_LOW   8'h92
`define SAT_ADDR_RLD_HIGH  8'h93
`define SAT_ADDR_CNT_LOW   8'h94
`define SAT_ADDR_CNT_HIGH  8'h95

// Control register field positions
`define SAT_BIT_HIGH_FLAG  7
`define SAT_BIT_LOW_FLAG   6
`define SAT_BIT_LOW_IEN    5
`define SAT_BIT_UNUSED4    4
`define SAT_BIT_SPLIT      3
`define SAT_BIT_RUN        2
`define SAT_BIT_UNUSED1    1
`define SAT_BIT_EXT_CLK    0

// Reset values
`define SAT_CTRL_RST       8'h00
`define SAT_RLD_RST        8'h00
`define SAT_CNT_RST        8'h00
`define SAT_RDATA_RST      8'h00
`define SAT_UNMAPPED_DATA  8'h00

// Count limits
`define SAT_BYTE_MAX       8'hFF
`define SAT_WORD_MAX       16'hFFFF
`define SAT_BYTE_ONE       8'h01
`define SAT_WORD_ONE       16'h0001

// Count source division factors
`define SAT_SYS_DIV        12
`define SAT_EXT_DIV        8

`endif

// ===== design/sat_pkg.sv
package sat_pkg;

  // Whole state of the timer core
  typedef struct packed {
    logic       high_overflow_flag;
    logic       low_overflow_flag;
    logic       low_byte_int_enable;
    logic       split_mode_enable;
    logic       run_control;
    logic       ext_clock_select;
    logic [7:0] reload_low;
    logic [7:0] reload_high;
    logic [7:0] count_low;
    logic [7:0] count_high;
    logic [7:0] rdata;
  } sat_state_t;

  // Whole state of the count source generator
  typedef struct packed {
    logic       ext_sync1;
    logic       ext_sync2;
    logic       ext_prev;
    logic [7:0] ext_cnt;
    logic [7:0] sys_cnt;
    logic       tick_sys;
    logic       tick_ext;
  } sat_tick_state_t;

endpackage

// ===== design/sat_tick_gen.sv
`timescale 1ns/1ps
`include "sat_defines.svh"

module sat_tick_gen
  import sat_pkg::*;
#(
  parameter int SYS_DIV = `SAT_SYS_DIV,
  parameter int EXT_DIV = `SAT_EXT_DIV
) (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic ext_osc_i,
  output logic      tick_sys_div_o,
  output logic      tick_ext_div_o
);

  localparam logic [7:0] SYS_LAST = 8'(SYS_DIV - 1);
  localparam logic [7:0] EXT_LAST = 8'(EXT_DIV - 1);

  sat_tick_state_t s_reg;
  sat_tick_state_t s_next;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_next = s_reg;
    s_next.tick_sys = 1'b0;
    s_next.tick_ext = 1'b0;
    // System clock prescaler, one pulse per SYS_DIV cycles
    if (s_reg.sys_cnt == SYS_LAST) begin
      s_next.sys_cnt  = 8'h00;
      s_next.tick_sys = 1'b1;
    end else begin
      s_next.sys_cnt = s_reg.sys_cnt + 8'h01;
    end
    // Oscillator brought into the system clock domain first
    s_next.ext_sync1 = ext_osc_i;
    s_next.ext_sync2 = s_reg.ext_sync1;
    s_next.ext_prev  = s_reg.ext_sync2;
    // Divide rising edges of the oscillator by EXT_DIV
    if (s_reg.ext_sync2 && !s_reg.ext_prev) begin
      if (s_reg.ext_cnt == EXT_LAST) begin
        s_next.ext_cnt  = 8'h00;
        s_next.tick_ext = 1'b1;
      end else begin
        s_next.ext_cnt = s_reg.ext_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick_sys_div_o = s_reg.tick_sys;
  assign tick_ext_div_o = s_reg.tick_ext;

endmodule

// ===== design/sat_timer.sv
//
// Contract
// - Split clear: one 16-bit up-counter; wrap loads reload, sets high flag.
// - 16-bit mode: request interrupt on each full overflow when enabled.
// - 16-bit mode: low-byte wrap also requests when low enable set.
// - Split set: two 8-bit counters, each reloading from its own byte.
// - Split mode: run control gates high counter only; low always counts.
// - Run control at bit 2 enables counting; governs whole 16-bit timer.
// - Byte clock select picks system clock, else ext select: /12 or ext /8.
// - External oscillator is synchronised, then its rising edges divided by 8.
// - High flag on high byte wrap; low flag on low byte wrap, any mode.
// - Split mode: request on high overflow, and low when low enable set.
// - Hardware never clears flags; software clears and checks both.
// - Control bits: 7 high flag, 6 low flag, 5 low enable, 3, 2, 0.
// - Control bits 4 and 1 read zero; writes to them are ignored.
// - Count registers hold 16-bit halves, or two split counter values.
//
`timescale 1ns/1ps
`include "sat_defines.svh"

module sat_timer
  import sat_pkg::*;
#(
  parameter int SYS_DIV = `SAT_SYS_DIV,
  parameter int EXT_DIV = `SAT_EXT_DIV
) (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic [7:0] sfr_wdata_i,
  output logic      [7:0] sfr_rdata_o,
  input  wire logic       timer_int_enable_i,
  input  wire logic       high_byte_clock_select_i,
  input  wire logic       low_byte_clock_select_i,
  input  wire logic       ext_osc_i,
  output logic            irq_o,
  output logic            high_overflow_flag_o,
  output logic            low_overflow_flag_o
);

  sat_state_t  s_reg;
  sat_state_t  s_next;

  logic        tick_sys_div;
  logic        tick_ext_div;
  logic        base_tick;
  logic        tick_low;
  logic        tick_high;
  logic        wr_ctrl;
  logic        wr_rld_low;
  logic        wr_rld_high;
  logic        wr_cnt_low;
  logic        wr_cnt_high;
  logic        set_high_flag;
  logic        set_low_flag;
  logic [15:0] count_word;
  logic [15:0] reload_word;
  logic [15:0] word_next;
  logic [7:0]  low_next;
  logic [7:0]  high_next;
  logic [7:0]  ctrl_view;
  logic [7:0]  rdata_next;

  ////////////////////////////////////////////////////////////////////////////
  // Count sources

  sat_tick_gen #(
    .SYS_DIV (SYS_DIV),
    .EXT_DIV (EXT_DIV)
  ) u_tick_gen (
    .clk_i          (clk_i),
    .reset_n_i      (reset_n_i),
    .ext_osc_i      (ext_osc_i),
    .tick_sys_div_o (tick_sys_div),
    .tick_ext_div_o (tick_ext_div)
  );

  // Shared divided source for both bytes
  always_comb begin
    if (s_reg.ext_clock_select) begin
      base_tick = tick_ext_div;
    end else begin
      base_tick = tick_sys_div;
    end
  end

  // Per-byte choice between the system clock and the divided source
  always_comb begin
    if (low_byte_clock_select_i) begin
      tick_low = 1'b1;
    end else begin
      tick_low = base_tick;
    end
    if (high_byte_clock_select_i) begin
      tick_high = 1'b1;
    end else begin
      tick_high = base_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register write decode

  always_comb begin
    wr_ctrl     = sfr_wr_i && (sfr_addr_i == `SAT_ADDR_CTRL);
    wr_rld_low  = sfr_wr_i && (sfr_addr_i == `SAT_ADDR_RLD_LOW);
    wr_rld_high = sfr_wr_i && (sfr_addr_i == `SAT_ADDR_RLD_HIGH);
    wr_cnt_low  = sfr_wr_i && (sfr_addr_i == `SAT_ADDR_CNT_LOW);
    wr_cnt_high = sfr_wr_i && (sfr_addr_i == `SAT_ADDR_CNT_HIGH);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counting

  assign count_word  = {s_reg.count_high, s_reg.count_low};
  assign reload_word = {s_reg.reload_high, s_reg.reload_low};

  always_comb begin
    set_high_flag = 1'b0;
    set_low_flag  = 1'b0;
    word_next     = count_word;
    low_next      = s_reg.count_low;
    high_next     = s_reg.count_high;
    if (!s_reg.split_mode_enable) begin
      // One 16-bit counter on the low byte's source
      if (s_reg.run_control && tick_low) begin
        if (count_word == `SAT_WORD_MAX) begin
          word_next     = reload_word;
          set_high_flag = 1'b1;
          set_low_flag  = 1'b1;
        end else begin
          word_next = count_word + `SAT_WORD_ONE;
          if (s_reg.count_low == `SAT_BYTE_MAX) begin
            set_low_flag = 1'b1;
          end
        end
      end
      low_next  = word_next[7:0];
      high_next = word_next[15:8];
    end else begin
      // Low byte free-running in split mode
      if (tick_low) begin
        if (s_reg.count_low == `SAT_BYTE_MAX) begin
          low_next     = s_reg.reload_low;
          set_low_flag = 1'b1;
        end else begin
          low_next = s_reg.count_low + `SAT_BYTE_ONE;
        end
      end
      // High byte gated by run control
      if (s_reg.run_control && tick_high) begin
        if (s_reg.count_high == `SAT_BYTE_MAX) begin
          high_next     = s_reg.reload_high;
          set_high_flag = 1'b1;
        end else begin
          high_next = s_reg.count_high + `SAT_BYTE_ONE;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register view

  always_comb begin
    ctrl_view                     = 8'h00;
    ctrl_view[`SAT_BIT_HIGH_FLAG] = s_reg.high_overflow_flag;
    ctrl_view[`SAT_BIT_LOW_FLAG]  = s_reg.low_overflow_flag;
    ctrl_view[`SAT_BIT_LOW_IEN]   = s_reg.low_byte_int_enable;
    ctrl_view[`SAT_BIT_UNUSED4]   = 1'b0;
    ctrl_view[`SAT_BIT_SPLIT]     = s_reg.split_mode_enable;
    ctrl_view[`SAT_BIT_RUN]       = s_reg.run_control;
    ctrl_view[`SAT_BIT_UNUSED1]   = 1'b0;
    ctrl_view[`SAT_BIT_EXT_CLK]   = s_reg.ext_clock_select;
  end

  // Read data registered one cycle after the address is presented
  always_comb begin
    unique case (sfr_addr_i)
      `SAT_ADDR_CTRL:     rdata_next = ctrl_view;
      `SAT_ADDR_RLD_LOW:  rdata_next = s_reg.reload_low;
      `SAT_ADDR_RLD_HIGH: rdata_next = s_reg.reload_high;
      `SAT_ADDR_CNT_LOW:  rdata_next = s_reg.count_low;
      `SAT_ADDR_CNT_HIGH: rdata_next = s_reg.count_high;
      default:            rdata_next = `SAT_UNMAPPED_DATA;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_next = s_reg;
    // Flags: a hardware set wins over a software clear
    if (wr_ctrl) begin
      s_next.high_overflow_flag  = sfr_wdata_i[`SAT_BIT_HIGH_FLAG]
                                   | set_high_flag;
      s_next.low_overflow_flag   = sfr_wdata_i[`SAT_BIT_LOW_FLAG]
                                   | set_low_flag;
      s_next.low_byte_int_enable = sfr_wdata_i[`SAT_BIT_LOW_IEN];
      s_next.split_mode_enable   = sfr_wdata_i[`SAT_BIT_SPLIT];
      s_next.run_control         = sfr_wdata_i[`SAT_BIT_RUN];
      s_next.ext_clock_select    = sfr_wdata_i[`SAT_BIT_EXT_CLK];
    end else begin
      s_next.high_overflow_flag  = s_reg.high_overflow_flag
                                   | set_high_flag;
      s_next.low_overflow_flag   = s_reg.low_overflow_flag
                                   | set_low_flag;
    end
    // Software writes take precedence over counting
    if (wr_rld_low) begin
      s_next.reload_low = sfr_wdata_i;
    end
    if (wr_rld_high) begin
      s_next.reload_high = sfr_wdata_i;
    end
    if (wr_cnt_low) begin
      s_next.count_low = sfr_wdata_i;
    end else begin
      s_next.count_low = low_next;
    end
    if (wr_cnt_high) begin
      s_next.count_high = sfr_wdata_i;
    end else begin
      s_next.count_high = high_next;
    end
    s_next.rdata = rdata_next;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_reg.high_overflow_flag  <= 1'b0;
      s_reg.low_overflow_flag   <= 1'b0;
      s_reg.low_byte_int_enable <= 1'b0;
      s_reg.split_mode_enable   <= 1'b0;
      s_reg.run_control         <= 1'b0;
      s_reg.ext_clock_select    <= 1'b0;
      s_reg.reload_low          <= `SAT_RLD_RST;
      s_reg.reload_high         <= `SAT_RLD_RST;
      s_reg.count_low           <= `SAT_CNT_RST;
      s_reg.count_high          <= `SAT_CNT_RST;
      s_reg.rdata               <= `SAT_RDATA_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Same expression serves both modes: low requests need the low enable
  assign irq_o = timer_int_enable_i
                 & (s_reg.high_overflow_flag
                    | (s_reg.low_overflow_flag
                       & s_reg.low_byte_int_enable));

  assign sfr_rdata_o          = s_reg.rdata;
  assign high_overflow_flag_o = s_reg.high_overflow_flag;
  assign low_overflow_flag_o  = s_reg.low_overflow_flag;

endmodule

// ===== testbench/sat_timer_chk.sv
`timescale 1ns/1ps

module sat_timer_chk (
  input wire logic       clk_i,
  input wire logic       reset_n_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic       sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic       timer_int_enable_i,
  input wire logic       irq_o,
  input wire logic       high_overflow_flag_o,
  input wire logic       low_overflow_flag_o
);
  default clocking cb_clk @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  wire ctrl_wr = sfr_wr_i && sfr_addr_i == 8'h91;

  ////////////////////////////////////////////////////////////////////////////
  a_hflag_kept: assert property (
    $fell(high_overflow_flag_o) |-> $past(ctrl_wr && !sfr_wdata_i[7]))
    else $error("high flag cleared without a control write");
  a_lflag_kept: assert property (
    $fell(low_overflow_flag_o) |-> $past(ctrl_wr && !sfr_wdata_i[6]))
    else $error("low flag cleared without a control write");
  a_flag_write: assert property (
    ctrl_wr && sfr_wdata_i[7] && sfr_wdata_i[6]
      |=> high_overflow_flag_o && low_overflow_flag_o)
    else $error("written flags not set");
  a_unmapped_zero: assert property (
    $past(sfr_addr_i) < 8'h91 || $past(sfr_addr_i) > 8'h95
      |-> sfr_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_unused_zero: assert property (
    $past(sfr_addr_i) == 8'h91 |-> !sfr_rdata_o[4] && !sfr_rdata_o[1])
    else $error("unused control bit reads one");
  a_irq_gated: assert property (
    !timer_int_enable_i |-> !irq_o)
    else $error("request while timer interrupt disabled");
  a_hflag_irq: assert property (
    timer_int_enable_i && high_overflow_flag_o |-> irq_o)
    else $error("no request with high flag set");
  a_reload_read: assert property (
    sfr_wr_i && sfr_addr_i == 8'h92 ##1 !sfr_wr_i && sfr_addr_i == 8'h92
      |=> sfr_rdata_o == $past(sfr_wdata_i, 2))
    else $error("reload low read back wrong");
endmodule

bind sat_timer sat_timer_chk chk_u (
  .clk_i               (clk_i),
  .reset_n_i           (reset_n_i),
  .sfr_addr_i          (sfr_addr_i),
  .sfr_wr_i            (sfr_wr_i),
  .sfr_wdata_i         (sfr_wdata_i),
  .sfr_rdata_o         (sfr_rdata_o),
  .timer_int_enable_i  (timer_int_enable_i),
  .irq_o               (irq_o),
  .high_overflow_flag_o(high_overflow_flag_o),
  .low_overflow_flag_o (low_overflow_flag_o)
);

// ===== testbench/split_autoreload_timer_tb.sv
`timescale 1ns/1ps

module split_autoreload_timer_tb;
  logic       clk_i = 0;
  logic       reset_n_i = 0;
  logic       sfr_wr_i = 0;
  logic       ext_osc_i = 0;
  logic       int_en = 0;
  logic       hi_sel = 1;
  logic       lo_sel = 1;
  logic [7:0] sfr_addr_i = 8'h00;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic [7:0] rdata;
  logic [7:0] v;
  logic       irq;
  logic       hflag;
  logic       lflag;
  int         n_fail = 0;
  int         compares = 0;
  int         cyc = 0;

  sat_timer dut_u (
    .clk_i                   (clk_i),
    .reset_n_i               (reset_n_i),
    .sfr_addr_i              (sfr_addr_i),
    .sfr_wr_i                (sfr_wr_i),
    .sfr_wdata_i             (sfr_wdata_i),
    .sfr_rdata_o             (rdata),
    .timer_int_enable_i      (int_en),
    .high_byte_clock_select_i(hi_sel),
    .low_byte_clock_select_i (lo_sel),
    .ext_osc_i               (ext_osc_i),
    .irq_o                   (irq),
    .high_overflow_flag_o    (hflag),
    .low_overflow_flag_o     (lflag)
  );

  always #50 clk_i = ~clk_i;
  // External oscillator: six system cycles per period
  always #300 ext_osc_i = ~ext_osc_i;

  task automatic report_and_stop;
    if (n_fail == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      report_and_stop;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] s, e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask

  task automatic cb(input string n, input logic s);
    chk(n, {7'h00, s}, 8'h01);
  endtask

  task automatic wr(input logic [7:0] a, d);
    sfr_addr_i = a;
    sfr_wr_i = 1;
    sfr_wdata_i = d;
    @(posedge clk_i);
    #1;
  endtask

  // Strobe stays up between back-to-back writes; reads and waits drop it
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfr_wr_i = 0;
    sfr_addr_i = a;
    @(posedge clk_i);
    #1;
    d = rdata;
  endtask

  task automatic wait_flag(input bit hi);
    sfr_wr_i = 0;
    for (int i = 0; i < 400; i++) begin
      if ((hi ? hflag : lflag) === 1'b1) break;
      @(posedge clk_i);
      #1;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk_i);
    #1;
    reset_n_i = 1;
    for (int a = 8'h91; a <= 8'h96; a++) begin
      rd(a[7:0], v);
      chk("reset", v, 8'h00);
    end
    int_en = 1;
    wr(8'h91, 8'hFF);
    rd(8'h91, v);
    chk("ctrl", v, 8'hED);
    cb("irq", irq);
    wr(8'h91, 8'h00);
    cb("irq off", !irq);
    wr(8'h91, 8'h08);
    wr(8'h94, 8'h55);
    rd(8'h94, v);
    chk("wr wins", v, 8'h55);
    rd(8'h94, v);
    chk("step", v, 8'h56);
    wr(8'h93, 8'h70);
    wr(8'h92, 8'hA0);
    rd(8'h92, v);
    chk("rld", v, 8'hA0);
    wr(8'h95, 8'h50);
    wr(8'h94, 8'hFE);
    wait_flag(0);
    rd(8'h95, v);
    chk("hi held", v, 8'h50);
    rd(8'h94, v);
    cb("lo rld", v >= 8'hA0 && v < 8'hA8);
    cb("no irq", !irq && !hflag);
    wr(8'h95, 8'hFE);
    wr(8'h91, 8'h6C);
    cb("lo irq", irq);
    wait_flag(1);
    wr(8'h91, 8'hC8);
    rd(8'h95, v);
    cb("hi rld", v >= 8'h70 && v < 8'h78 && hflag);
    wr(8'h91, 8'h00);
    wr(8'h93, 8'h12);
    wr(8'h92, 8'h34);
    wr(8'h95, 8'hFF);
    wr(8'h94, 8'hF0);
    sfr_wr_i = 0;
    repeat (20) @(posedge clk_i);
    #1;
    rd(8'h94, v);
    chk("stopped", v, 8'hF0);
    wr(8'h91, 8'h04);
    wait_flag(1);
    wr(8'h91, 8'hC0);
    rd(8'h95, v);
    chk("w rld hi", v, 8'h12);
    rd(8'h94, v);
    cb("w rld lo", v >= 8'h34 && v < 8'h3C);
    cb("w flags", lflag && irq);
    wr(8'h91, 8'h00);
    wr(8'h94, 8'hFE);
    wr(8'h91, 8'h24);
    wait_flag(0);
    cb("lo wrap", irq && !hflag);
    wr(8'h91, 8'h40);
    cb("ien off", !irq);
    rd(8'h95, v);
    chk("carry", v, 8'h13);
    lo_sel = 0;
    wr(8'h91, 8'h08);
    wr(8'h94, 8'h00);
    sfr_wr_i = 0;
    repeat (120) @(posedge clk_i);
    #1;
    rd(8'h94, v);
    chk("div12", v, 8'h0A);
    hi_sel = 0;
    wr(8'h91, 8'h0D);
    wr(8'h94, 8'h00);
    wr(8'h95, 8'h00);
    sfr_wr_i = 0;
    repeat (479) @(posedge clk_i);
    #1;
    rd(8'h94, v);
    chk("ext lo", v, 8'h0A);
    rd(8'h95, v);
    chk("ext hi", v, 8'h0A);
    report_and_stop;
  end
endmodule
